// ===== rtl/ssr_pkg.sv
// Constants, register map and field layout of the synchronous serial receiver.
// Assumes a single 40 MHz clock and an AXI4-Lite master reaching the registers.
// Summary of operation
// - Master receiver releases the data line and reads serial data from it.
// - Reception starts when single (master only) or continuous receive enable is set.
// - Single receive clocks one character, then clears its own enable.
// - Continuous receive clocks without pause until its enable is cleared or an overrun occurs.
// - Clearing continuous mid-character stops the clock and drops the partial character.
// - Both enables set: single clears after first character, continuous carries on.
// - Data is sampled on the trailing clock edge into the shift register.
// - A full character moves into the two-deep FIFO and sets receive pending.
// - Data register shows the oldest entry's low byte; pending holds while unread.
// - Slave releases the clock line and takes the external master's clock.
// - Slave takes one bit per received clock, valid at the trailing edge.
// - A third character into a full FIFO sets overrun and is discarded.
// - During overrun stored entries stay readable and nothing new is accepted.
// - Single-mode overrun clears on data read; the flag is not writable.
// - Continuous-mode overrun clears by clearing continuous receive or port enable.
// - Nine-bit mode shifts nine bits; the ninth of the oldest entry is a status bit.
// - Clock polarity bit sets the shift clock idle level high or low.
// - Master clock source bit selects master driving the clock, else slave.
package ssr_pkg;
  localparam logic [3:0] SSR_ADDR_BAUD_CTRL = 4'h0;
  localparam logic [3:0] SSR_ADDR_RX_STAT = 4'h4;
  localparam logic [3:0] SSR_ADDR_DIV_LO = 4'h8;
  localparam logic [3:0] SSR_ADDR_DIV_HI = 4'hC;
  localparam logic [5:0] SSR_ADDR_TX_DATA = 6'h10;
  localparam logic [5:0] SSR_ADDR_TX_STAT = 6'h14;
  localparam logic [5:0] SSR_ADDR_RX_DATA = 6'h18;
  localparam int SSR_ADDR_W = 6;
  // Bit positions in the baud control register.
  localparam int SSR_B_POL = 4;
  localparam int SSR_B_WIDE = 3;
  // Bit positions in the receive status and control register.
  localparam int SSR_B_PEN = 7;
  localparam int SSR_B_RX9 = 6;
  localparam int SSR_B_SINGLE_RECEIVE_ENABLE = 5;
  localparam int SSR_B_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int SSR_B_OVR = 1;
  localparam int SSR_B_D9 = 0;
  // Bit positions in the transmit status and control register.
  localparam int SSR_B_MASTER_CLOCK_SOURCE = 7;
  localparam int SSR_B_SYNC = 4;
  localparam int SSR_B_HS = 2;
  // Pending flag is exposed in the receive data word above the data byte.
  localparam int SSR_B_PEND = 8;
  localparam logic [3:0] SSR_BITS8 = 4'h8;
  localparam logic [3:0] SSR_BITS9 = 4'h9;
  localparam logic [1:0] SSR_RESP_OKAY = 2'b00;
  localparam logic [1:0] SSR_RESP_SLVERR = 2'b10;
  localparam logic [7:0] SSR_RST_BYTE = 8'h00;
  localparam logic [15:0] SSR_DIV_ONE = 16'h0001;
endpackage

// ===== rtl/ssr_receiver.sv
// Synchronous serial receive engine with its AXI4-Lite register slave.
// Assumes the link pins come from outside the 40 MHz domain and resolves no pad wires itself.
`timescale 1ns/1ps
`default_nettype none
module ssr_receiver (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic data_line_i,
  output logic data_line_o,
  output logic data_line_oe,
  input wire logic clock_line_i,
  output logic clock_line_o,
  output logic clock_line_oe
);
  import ssr_pkg::*;

  typedef struct packed {
    logic [7:0] baud_r;
    logic [7:0] rxst_r;
    logic [7:0] divlo_r;
    logic [7:0] divhi_r;
    logic [7:0] txdat_r;
    logic [7:0] txst_r;
    logic aw_r;
    logic [5:0] awa_r;
    logic w_r;
    logic [31:0] wd_r;
    logic [3:0] ws_r;
    logic bv_r;
    logic [1:0] bresp_r;
    logic rv_r;
    logic [31:0] rd_r;
    logic [1:0] rresp_r;
    logic [1:0] dsync_r;
    logic [1:0] csync_r;
    logic cprev_r;
    logic [15:0] brg_r;
    logic [1:0] pre_r;
    logic sck_r;
    logic active_r;
    logic [3:0] cnt_r;
    logic [8:0] shift_r;
    logic [8:0] fifo0_r;
    logic [8:0] fifo1_r;
    logic [1:0] fill_r;
    logic ovr_single_r;
  } ssr_state_t;

  ssr_state_t s_r;
  ssr_state_t s_nxt;

  // Decodes a word address against a register offset.
  function automatic logic ssr_hit(input logic [5:0] a, input logic [5:0] off);
    ssr_hit = (a[5:2] == off[5:2]);
  endfunction

  // Applies byte lane zero of a write to an eight-bit register.
  function automatic logic [7:0] ssr_wbyte(input logic [7:0] old, input logic [31:0] d, input logic [3:0] st);
    ssr_wbyte = st[0] ? d[7:0] : old;
  endfunction

  logic pen, master, sync_mode, rx9, single_receive_enable, continuous_receive_enable, enable_rx;
  logic [3:0] nbits;
  logic trailing;
  logic ck_rise, ck_fall;
  logic done_char;
  logic wr_go, rd_go;
  logic rd_data_pop;
  logic [8:0] captured;

  // Combinational decode of the mode bits, used throughout the engine.
  assign pen = s_r.rxst_r[SSR_B_PEN];
  assign master = s_r.txst_r[SSR_B_MASTER_CLOCK_SOURCE];
  assign sync_mode = s_r.txst_r[SSR_B_SYNC];
  assign rx9 = s_r.rxst_r[SSR_B_RX9];
  assign single_receive_enable = s_r.rxst_r[SSR_B_SINGLE_RECEIVE_ENABLE];
  assign continuous_receive_enable = s_r.rxst_r[SSR_B_CONTINUOUS_RECEIVE_ENABLE];
  assign nbits = rx9 ? SSR_BITS9 : SSR_BITS8;
  // Continuous enable keeps the engine clocking until software drops it or an overrun occurs.
  assign enable_rx = pen && sync_mode && ((master && (single_receive_enable || continuous_receive_enable)) || (!master && continuous_receive_enable));
  assign ck_rise = s_r.csync_r[1] && !s_r.cprev_r;
  assign ck_fall = !s_r.csync_r[1] && s_r.cprev_r;
  assign wr_go = s_r.aw_r && s_r.w_r && !s_r.bv_r;
  assign rd_go = s_axi_arvalid && !s_r.rv_r;
  assign rd_data_pop = rd_go && ssr_hit(s_axi_araddr, SSR_ADDR_RX_DATA);

  // Next-state logic for the bus slave, baud generator, shifter and FIFO.
  always_comb begin
    logic tick;
    logic [15:0] div;
    logic [8:0] nshift;
    logic [7:0] wb;
    logic ovr_set;
    tick = 1'b0;
    wb = ssr_wbyte(s_r.rxst_r, s_r.wd_r, s_r.ws_r);
    ovr_set = 1'b0;
    div = {s_r.divhi_r, s_r.divlo_r};
    nshift = s_r.shift_r;
    trailing = 1'b0;
    done_char = 1'b0;
    captured = s_r.shift_r;
    s_nxt = s_r;
    // Both link pins pass two flops before any logic reads them.
    s_nxt.dsync_r = {s_r.dsync_r[0], data_line_i};
    s_nxt.csync_r = {s_r.csync_r[0], clock_line_i};
    s_nxt.cprev_r = s_r.csync_r[1];
    // Divisor: 16-bit pair when wide, else the low byte; prescaled by four unless high speed.
    if (!s_r.baud_r[SSR_B_WIDE]) begin
      div = {SSR_RST_BYTE, s_r.divlo_r};
    end
    if (!enable_rx || !master) begin
      s_nxt.brg_r = div;
      s_nxt.pre_r = 2'b00;
    end else if (s_r.brg_r == 16'h0000) begin
      s_nxt.brg_r = div;
      s_nxt.pre_r = s_r.pre_r + 2'b01;
      tick = s_r.txst_r[SSR_B_HS] || (s_r.pre_r == 2'b11);
    end else begin
      s_nxt.brg_r = s_r.brg_r - SSR_DIV_ONE;
    end
    // Master toggles its internal clock phase per tick; the second half is the trailing edge.
    if (master) begin
      if (tick && s_r.active_r) begin
        s_nxt.sck_r = !s_r.sck_r;
        trailing = s_r.sck_r;
      end
    end else begin
      // Slave trailing edge is the falling edge with idle low, rising with idle high.
      trailing = s_r.baud_r[SSR_B_POL] ? ck_rise : ck_fall;
    end
    if (enable_rx && !s_r.rxst_r[SSR_B_OVR]) begin
      s_nxt.active_r = 1'b1;
    end else begin
      // Losing the enable mid-character stops the clock and drops the bits.
      s_nxt.active_r = 1'b0;
      s_nxt.sck_r = 1'b0;
      s_nxt.cnt_r = 4'h0;
      trailing = 1'b0;
    end
    if (trailing && s_r.active_r) begin
      nshift = {s_r.dsync_r[1], s_r.shift_r[8:1]};
      s_nxt.shift_r = nshift;
      if (s_r.cnt_r == nbits - 4'h1) begin
        done_char = 1'b1;
        s_nxt.cnt_r = 4'h0;
        captured = rx9 ? nshift : {1'b0, nshift[8:1]};
      end else begin
        s_nxt.cnt_r = s_r.cnt_r + 4'h1;
      end
    end
    // FIFO pop on a data read, then push of a finished character.
    if (rd_data_pop && s_r.fill_r != 2'd0) begin
      s_nxt.fifo0_r = s_r.fifo1_r;
      s_nxt.fill_r = s_r.fill_r - 2'd1;
      if (s_r.ovr_single_r) begin
        s_nxt.rxst_r[SSR_B_OVR] = 1'b0;
        s_nxt.ovr_single_r = 1'b0;
      end
    end
    if (done_char) begin
      if (s_r.fill_r == 2'd2 && !rd_data_pop) begin
        s_nxt.rxst_r[SSR_B_OVR] = 1'b1;
        ovr_set = 1'b1;
        s_nxt.ovr_single_r = !continuous_receive_enable;
      end else if (s_nxt.fill_r == 2'd0) begin
        s_nxt.fifo0_r = captured;
        s_nxt.fill_r = 2'd1;
      end else begin
        s_nxt.fifo1_r = captured;
        s_nxt.fill_r = 2'd2;
      end
      if (master && single_receive_enable) begin
        s_nxt.rxst_r[SSR_B_SINGLE_RECEIVE_ENABLE] = 1'b0;
      end
    end
    // Bus write capture: address and data are taken independently.
    if (s_axi_awvalid && !s_r.aw_r) begin
      s_nxt.aw_r = 1'b1;
      s_nxt.awa_r = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_r) begin
      s_nxt.w_r = 1'b1;
      s_nxt.wd_r = s_axi_wdata;
      s_nxt.ws_r = s_axi_wstrb;
    end
    if (wr_go) begin
      s_nxt.aw_r = 1'b0;
      s_nxt.w_r = 1'b0;
      s_nxt.bv_r = 1'b1;
      s_nxt.bresp_r = SSR_RESP_OKAY;
      if (ssr_hit(s_r.awa_r, {2'b00, SSR_ADDR_BAUD_CTRL})) begin
        s_nxt.baud_r = ssr_wbyte(s_r.baud_r, s_r.wd_r, s_r.ws_r);
      end else if (ssr_hit(s_r.awa_r, {2'b00, SSR_ADDR_RX_STAT})) begin
        // Overrun and ninth bit are hardware status; write data leaves them alone.
        s_nxt.rxst_r[7:2] = wb[7:2];
        if (done_char && master && single_receive_enable) begin
          s_nxt.rxst_r[SSR_B_SINGLE_RECEIVE_ENABLE] = 1'b0;
        end
        if (!s_nxt.rxst_r[SSR_B_CONTINUOUS_RECEIVE_ENABLE] || !s_nxt.rxst_r[SSR_B_PEN]) begin
          // An overrun raised in this very cycle wins over a continuous-enable clear; a write clearing port enable still clears it.
          if ((!s_nxt.ovr_single_r && !ovr_set) || !s_nxt.rxst_r[SSR_B_PEN]) begin
            s_nxt.rxst_r[SSR_B_OVR] = 1'b0;
          end
        end
        if (!s_nxt.rxst_r[SSR_B_PEN]) begin
          // Port enable low resets the whole engine, FIFO included.
          s_nxt.fill_r = 2'd0;
          s_nxt.ovr_single_r = 1'b0;
        end
      end else if (ssr_hit(s_r.awa_r, {2'b00, SSR_ADDR_DIV_LO})) begin
        s_nxt.divlo_r = ssr_wbyte(s_r.divlo_r, s_r.wd_r, s_r.ws_r);
      end else if (ssr_hit(s_r.awa_r, {2'b00, SSR_ADDR_DIV_HI})) begin
        s_nxt.divhi_r = ssr_wbyte(s_r.divhi_r, s_r.wd_r, s_r.ws_r);
      end else if (ssr_hit(s_r.awa_r, SSR_ADDR_TX_DATA)) begin
        s_nxt.txdat_r = ssr_wbyte(s_r.txdat_r, s_r.wd_r, s_r.ws_r);
      end else if (ssr_hit(s_r.awa_r, SSR_ADDR_TX_STAT)) begin
        s_nxt.txst_r = ssr_wbyte(s_r.txst_r, s_r.wd_r, s_r.ws_r);
      end else if (!ssr_hit(s_r.awa_r, SSR_ADDR_RX_DATA)) begin
        s_nxt.bresp_r = SSR_RESP_SLVERR;
      end
    end
    if (s_r.bv_r && s_axi_bready) begin
      s_nxt.bv_r = 1'b0;
    end
    // Reads answer one cycle after the address is taken.
    if (rd_go) begin
      s_nxt.rv_r = 1'b1;
      s_nxt.rresp_r = SSR_RESP_OKAY;
      s_nxt.rd_r = 32'h0000_0000;
      if (ssr_hit(s_axi_araddr, {2'b00, SSR_ADDR_BAUD_CTRL})) begin
        s_nxt.rd_r[7:0] = s_r.baud_r;
      end else if (ssr_hit(s_axi_araddr, {2'b00, SSR_ADDR_RX_STAT})) begin
        s_nxt.rd_r[7:0] = s_r.rxst_r;
        s_nxt.rd_r[SSR_B_D9] = (s_r.fill_r != 2'd0) && rx9 && s_r.fifo0_r[8];
      end else if (ssr_hit(s_axi_araddr, {2'b00, SSR_ADDR_DIV_LO})) begin
        s_nxt.rd_r[7:0] = s_r.divlo_r;
      end else if (ssr_hit(s_axi_araddr, {2'b00, SSR_ADDR_DIV_HI})) begin
        s_nxt.rd_r[7:0] = s_r.divhi_r;
      end else if (ssr_hit(s_axi_araddr, SSR_ADDR_TX_STAT)) begin
        s_nxt.rd_r[7:0] = s_r.txst_r;
      end else if (ssr_hit(s_axi_araddr, SSR_ADDR_RX_DATA)) begin
        s_nxt.rd_r[7:0] = s_r.fifo0_r[7:0];
        s_nxt.rd_r[SSR_B_PEND] = (s_r.fill_r != 2'd0);
      end else if (!ssr_hit(s_axi_araddr, SSR_ADDR_TX_DATA)) begin
        s_nxt.rresp_r = SSR_RESP_SLVERR;
      end
    end
    if (s_r.rv_r && s_axi_rready) begin
      s_nxt.rv_r = 1'b0;
    end
  end

  // Single register stage for all state; synchronous active-low reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Bus handshakes and pin drivers.
  assign s_axi_awready = !s_r.aw_r;
  assign s_axi_wready = !s_r.w_r;
  assign s_axi_bvalid = s_r.bv_r;
  assign s_axi_bresp = s_r.bresp_r;
  assign s_axi_arready = !s_r.rv_r;
  assign s_axi_rvalid = s_r.rv_r;
  assign s_axi_rdata = s_r.rd_r;
  assign s_axi_rresp = s_r.rresp_r;
  assign data_line_o = 1'b0;
  assign data_line_oe = 1'b0;
  // Clock is driven only by an enabled master; idle level follows polarity.
  assign clock_line_oe = pen && sync_mode && master;
  assign clock_line_o = s_r.sck_r ^ s_r.baud_r[SSR_B_POL];

  // Checks of the receive engine behaviour.
  fifo_bound_a: assert property (@(posedge aclk) disable iff (!aresetn) s_r.fill_r <= 2'd2)
    else $error("fifo fill above two");
  pend_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_go && ssr_hit(s_axi_araddr, SSR_ADDR_RX_DATA) && s_r.fill_r != 2'd0) |=> s_axi_rdata[SSR_B_PEND])
    else $error("pending not shown with data");
  ovr_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (done_char && s_r.fill_r == 2'd2 && !rd_data_pop) |=> (s_r.fill_r == 2'd2 && $stable(s_r.fifo0_r)
    && s_r.rxst_r[SSR_B_OVR]))
    else $error("overrun disturbed fifo");
  ovr_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_r.rxst_r[SSR_B_OVR] |-> !done_char)
    else $error("character accepted in overrun");
  single_receive_enable_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (done_char && master && single_receive_enable && !wr_go) |=> !s_r.rxst_r[SSR_B_SINGLE_RECEIVE_ENABLE])
    else $error("single enable not cleared");
  continuous_receive_enable_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (master && !enable_rx) |=> ##1 (s_r.cnt_r == 4'h0 && !s_r.sck_r))
    else $error("clock not stopped");
  data_rel_a: assert property (@(posedge aclk) disable iff (!aresetn) !data_line_oe)
    else $error("data line driven");
  slave_ck_a: assert property (@(posedge aclk) disable iff (!aresetn) !master |-> !clock_line_oe)
    else $error("slave drives clock");
  idle_pol_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !s_r.active_r ##1 !s_r.active_r |-> clock_line_o == s_r.baud_r[SSR_B_POL])
    else $error("idle level wrong");
  cnt_lim_a: assert property (@(posedge aclk) disable iff (!aresetn) s_r.cnt_r < nbits)
    else $error("bit count beyond character");
  char_c: cover property (@(posedge aclk) disable iff (!aresetn) done_char);
  ovr_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(s_r.rxst_r[SSR_B_OVR]));
  nine_c: cover property (@(posedge aclk) disable iff (!aresetn) done_char && rx9);
  slave_c: cover property (@(posedge aclk) disable iff (!aresetn) done_char && !master);
endmodule
`default_nettype wire

// ===== sim/ssr_partner.sv
// Behavioural far-side device for the synchronous receiver link: slave to a master, master to a slave.
// Assumes the bench pulses load before each character train and pulses go to start a slave frame.
`timescale 1ns/1ps
`default_nettype none
module ssr_partner (
  input wire logic clk_o,
  input wire logic clk_oe,
  input wire logic pol,
  input wire logic go,
  input wire logic load,
  input wire logic [3:0] nbits,
  input wire logic [8:0] base,
  output logic clk_i,
  output logic dat
);
  logic [8:0] word;
  int idx;
  // Next bit leaves LSB first; successive characters count up from the base value.
  task automatic put();
    dat = word[idx];
    idx++;
    if (idx == nbits) begin
      idx = 0;
      word++;
    end
  endtask
  initial begin
    clk_i = 1'h0;
    dat = 1'h0;
    word = 9'h000;
    idx = 0;
  end
  // Restarting the count keeps us aligned after an aborted character.
  always @(posedge load) begin
    word = base;
    idx = 0;
  end
  // Bits change on the leading edge; once the hold time runs out the line is scrambled on purpose.
  always @(clk_o) begin
    if (clk_oe === 1'h1) begin
      if (clk_o !== pol) put();
      else begin
        #150;
        dat = ~dat;
      end
    end
  end
  // One character of clocks only, then the clock rests at its idle level.
  always @(posedge go) begin
    repeat (nbits) begin
      clk_i = ~pol;
      put();
      #100;
      clk_i = pol;
      #50;
      dat = ~dat;
      #50;
    end
  end
endmodule
`default_nettype wire

// ===== sim/ssr_receiver_bench.sv
// Self-checking bench for the synchronous serial receiver, driving its AXI4-Lite slave.
// Assumes the partner model stands on the link pins and the 40 MHz clock is made here.
`timescale 1ns/1ps
`default_nettype none
module ssr_receiver_bench;
  import ssr_pkg::*;
  localparam logic [5:0] A_BD = {2'h0, SSR_ADDR_BAUD_CTRL};
  localparam logic [5:0] A_RS = {2'h0, SSR_ADDR_RX_STAT};
  localparam logic [5:0] A_DL = {2'h0, SSR_ADDR_DIV_LO};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, data_line_i, data_line_o, data_line_oe;
  logic clock_line_i, clock_line_o, clock_line_oe, pol, go, load, prev, pdat, pclk;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, nb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [8:0] base;
  int failures, comparisons, edges, gap, since, e, n;
  ssr_receiver i_ssr_receiver (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .data_line_i,
    .data_line_o, .data_line_oe, .clock_line_i, .clock_line_o, .clock_line_oe);
  ssr_partner i_ssr_partner (.clk_o(clock_line_o), .clk_oe(clock_line_oe), .pol(pol), .go(go), .load(load),
    .nbits(nb), .base(base), .clk_i(pclk), .dat(pdat));
  // Pin levels resolved from whoever drives them.
  assign data_line_i = data_line_oe ? data_line_o : pdat;
  assign clock_line_i = clock_line_oe ? clock_line_o : pclk;
  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end
  // Counts leading shift-clock edges and the cycles between the last two of them.
  always @(posedge aclk) begin
    prev <= clock_line_i;
    if (clock_line_i !== prev && clock_line_i !== pol) begin
      edges <= edges + 1;
      gap <= since;
      since <= 1;
    end else since <= since + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic test_done();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One AXI4-Lite write or read; ready is judged at the falling edge so the rising edge acts on settled values.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    logic ta, tw, tr, dn;
    int k;
    @(posedge aclk);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
    end
    dn = 1'h0;
    for (k = 0; k < 200 && !dn; k++) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tr = s_axi_arvalid & s_axi_arready;
      dn = w ? (s_axi_bvalid === 1'h1) : (s_axi_rvalid === 1'h1);
      rs = w ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tr) s_axi_arvalid <= 1'h0;
      if (dn) s_axi_bready <= 1'h0;
      if (dn) s_axi_rready <= 1'h0;
    end
    if (!dn) failures++;
  endtask
  task automatic poll(input int b, input logic v);
    for (n = 0; n < 300; n++) begin
      bus(1'h0, A_RS, 32'h0);
      if (rd[b] === v) break;
    end
  endtask
  // Loads the partner, then writes the receive control byte that starts things off.
  task automatic start(input logic [7:0] s, input logic [8:0] b, input logic [3:0] c);
    @(posedge aclk);
    base <= b;
    nb <= c;
    load <= 1'h1;
    @(posedge aclk);
    load <= 1'h0;
    @(negedge aclk);
    edges = 0;
    bus(1'h1, A_RS, {24'h0, s});
  endtask
  task automatic t_regs();
    bus(1'h0, A_BD, 32'h0);
    chk(rd, 32'h0, "baud reset");
    bus(1'h1, A_DL, 32'h7);
    bus(1'h0, A_DL, 32'h0);
    chk(rd, 32'h7, "divisor");
    bus(1'h0, 6'h1C, 32'h0);
    chk(rs, SSR_RESP_SLVERR, "unmapped");
    bus(1'h1, 6'h1C, 32'h0);
    chk(rs, SSR_RESP_SLVERR, "unmapped write");
    bus(1'h1, A_RS, 32'h82);
    bus(1'h0, A_RS, 32'h0);
    chk(rd, 32'h80, "overrun written");
    bus(1'h1, SSR_ADDR_TX_STAT, 32'h94);
    chk(clock_line_oe, 1'h1, "master drive");
  endtask
  task automatic t_single(input logic p);
    @(posedge aclk);
    pol <= p;
    bus(1'h1, A_BD, {27'h0, p, 4'h0});
    start(8'hA0, 9'h0A5, 4'h8);
    poll(SSR_B_SINGLE_RECEIVE_ENABLE, 1'h0);
    chk(edges, 8, "clock count");
    chk(gap, 16, "bit period");
    chk(clock_line_o, p, "idle level");
    chk(data_line_oe, 1'h0, "data drive");
    bus(1'h0, SSR_ADDR_RX_DATA, 32'h0);
    chk(rd, 32'h1A5, "byte");
    bus(1'h0, SSR_ADDR_RX_DATA, 32'h0);
    chk(rd[8], 1'h0, "drained");
  endtask
  task automatic t_overrun();
    start(8'hA0, 9'h011, 4'h8);
    poll(SSR_B_SINGLE_RECEIVE_ENABLE, 1'h0);
    start(8'hA0, 9'h022, 4'h8);
    poll(SSR_B_SINGLE_RECEIVE_ENABLE, 1'h0);
    start(8'hA0, 9'h033, 4'h8);
    poll(SSR_B_SINGLE_RECEIVE_ENABLE, 1'h0);
    bus(1'h0, A_RS, 32'h0);
    chk(rd[SSR_B_OVR], 1'h1, "overrun set");
    bus(1'h0, SSR_ADDR_RX_DATA, 32'h0);
    chk(rd, 32'h111, "first kept");
    bus(1'h0, A_RS, 32'h0);
    chk(rd[SSR_B_OVR], 1'h0, "overrun read");
    bus(1'h0, SSR_ADDR_RX_DATA, 32'h0);
    chk(rd, 32'h122, "second kept");
    bus(1'h0, SSR_ADDR_RX_DATA, 32'h0);
    chk(rd[8], 1'h0, "third dropped");
  endtask
  task automatic t_cont();
    start(8'hB0, 9'h040, 4'h8);
    poll(SSR_B_SINGLE_RECEIVE_ENABLE, 1'h0);
    chk(rd[SSR_B_CONTINUOUS_RECEIVE_ENABLE], 1'h1, "continuous kept");
    poll(SSR_B_OVR, 1'h1);
    chk(edges >= 24, 1'h1, "clocks run on");
    bus(1'h1, A_RS, 32'h80);
    bus(1'h0, A_RS, 32'h0);
    chk(rd[SSR_B_OVR], 1'h0, "overrun cleared");
    bus(1'h0, SSR_ADDR_RX_DATA, 32'h0);
    chk(rd, 32'h140, "fifo order");
    bus(1'h0, SSR_ADDR_RX_DATA, 32'h0);
    chk(rd, 32'h141, "fifo order");
    start(8'h90, 9'h055, 4'h8);
    for (n = 0; n < 400 && edges < 4; n++) @(posedge aclk);
    bus(1'h1, A_RS, 32'h80);
    e = edges;
    repeat (64) @(posedge aclk);
    chk(edges, e, "clock halted");
    bus(1'h0, SSR_ADDR_RX_DATA, 32'h0);
    chk(rd[8], 1'h0, "partial dropped");
  endtask
  task automatic t_nine();
    start(8'hE0, 9'h1C3, 4'h9);
    poll(SSR_B_SINGLE_RECEIVE_ENABLE, 1'h0);
    chk(edges, 9, "nine clocks");
    chk(rd[SSR_B_D9], 1'h1, "ninth bit");
    bus(1'h0, SSR_ADDR_RX_DATA, 32'h0);
    chk(rd, 32'h1C3, "low byte");
  endtask
  task automatic t_slave();
    bus(1'h1, SSR_ADDR_TX_STAT, 32'h10);
    chk(clock_line_oe, 1'h0, "clock released");
    start(8'h90, 9'h03C, 4'h8);
    @(posedge aclk);
    go <= 1'h1;
    @(posedge aclk);
    go <= 1'h0;
    for (n = 0; n < 400 && edges < 8; n++) @(posedge aclk);
    repeat (8) @(posedge aclk);
    bus(1'h0, SSR_ADDR_RX_DATA, 32'h0);
    chk(rd, 32'h13C, "slave byte");
  endtask
  // Time-zero values, five cycles of reset, then the scenarios.
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go, load} = 8'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, base, nb} = 57'h0;
    s_axi_wstrb = 4'hF;
    pol = 1'h0;
    {failures, comparisons, edges, gap, since} = 160'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_single(1'h1);
    t_single(1'h0);
    t_overrun();
    t_cont();
    t_nine();
    t_slave();
    test_done();
  end
  // Cuts a hang short well beyond the few thousand cycles the scenarios need.
  initial begin
    repeat (40000) @(posedge aclk);
    failures++;
    test_done();
  end
endmodule
`default_nettype wire
